// ### common/accel_pkg.sv
// constants and types of the checksum and crc accelerator
package accel_pkg;

  // ============================================================
  // register map (index, byte address is four times it)
  localparam int             ADDR_W      = 18;
  localparam logic [15:0]    CFG_INDEX   = 16'ha078;
  localparam logic [15:0]    DATA0_INDEX = 16'ha07c;
  localparam logic [15:0]    DATA1_INDEX = 16'ha07d;
  localparam logic [15:0]    DATA2_INDEX = 16'ha07e;
  localparam logic [15:0]    DATA3_INDEX = 16'ha07f;
  localparam logic [ADDR_W-1:0] CFG_ADDR   = {CFG_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA0_ADDR = {DATA0_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA1_ADDR = {DATA1_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA2_ADDR = {DATA2_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA3_ADDR = {DATA3_INDEX, 2'b00};

  // ============================================================
  // configuration fields and reset values
  localparam int          ALG_LSB    = 0;
  localparam int          SEED_BIT   = 3;
  localparam int          CARRY_BIT  = 4;
  localparam int          REV_BIT    = 5;
  localparam int          WIDTH_LSB  = 6;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          BUF_DEPTH  = 2;

  // ============================================================
  // algorithms, polynomials and seeds
  typedef enum logic [2:0] {
    ALG_OFF    = 3'h0,
    ALG_SUM8   = 3'h1,
    ALG_SUM32  = 3'h2,
    ALG_CRC16A = 3'h3,
    ALG_CRC16B = 3'h4,
    ALG_CRC32  = 3'h5,
    ALG_RSVD   = 3'h6,
    ALG_CLEAR  = 3'h7
  } algo_e;

  localparam logic [31:0] POLY_CRC16A = 32'h0000_8005;
  localparam logic [31:0] POLY_CRC16B = 32'h0000_1021;
  localparam logic [31:0] POLY_CRC32  = 32'h04c1_1db7;
  localparam logic [31:0] SEED_SUM    = 32'h0000_0000;
  localparam logic [31:0] SEED_CRC16  = 32'h0000_ffff;
  localparam logic [31:0] SEED_CRC32  = 32'hffff_ffff;

  // ============================================================
  // buffered work items and engine states
  typedef enum logic [1:0] {
    ENT_DATA  = 2'h0,
    ENT_SEED  = 2'h1,
    ENT_CLEAR = 2'h2
  } entry_kind_e;

  typedef struct packed {
    entry_kind_e kind;
    logic [1:0]  nbytes;
    logic [31:0] word;
  } entry_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } eng_state_e;

endpackage : accel_pkg

// ### verilog/accel_pair_buffer.sv
// small valid/ready buffer between the register port and the engine
`timescale 1ns/1ps
`default_nettype none

module accel_pair_buffer
  import accel_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ============================================================
  // storage
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ============================================================
  // pointers and fill level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : accel_pair_buffer

`default_nettype wire

// ### verilog/checksum_crc_accelerator.sv
// checksum and crc accelerator with an axi4-lite register port
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module checksum_crc_accelerator
  import accel_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  localparam int ENTRY_W = $bits(entry_s);

  // configuration
  logic [1:0]  input_width_select;
  logic        reverse_order;
  logic        carry_discard;
  logic        seed_entry;
  algo_e       algorithm_select;

  // write channel holding
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_byte;
  logic              wr_lane0;
  logic [31:8]       data_hold;

  // engine
  eng_state_e  state;
  logic [31:0] acc;
  logic        carry;
  logic [31:0] cur_word;
  logic [1:0]  cur_last;
  logic [1:0]  lane;
  logic [32:0] step_out;
  logic [7:0]  step_byte;
  logic [1:0]  step_lane;
  logic        busy;

  // buffer
  entry_s      push_entry;
  entry_s      pop_entry;
  logic        push_valid;
  logic        push_ready;
  logic        pop_valid;
  logic        pop_ready;
  logic        commit;
  logic        needs_push;
  logic        is_data0;
  logic        is_clear;
  logic [31:0] engine_input_word;

  // ============================================================
  // helpers
  function automatic logic [31:0] width_mask(input logic [1:0] w);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      m[i] = (i < (int'(w) + 1) * 8);
    end
    return m;
  endfunction : width_mask

  function automatic logic [31:0] mirror(input logic [31:0] d, input logic [1:0] w);
    logic [31:0] r;
    int          n;
    r = 32'h0000_0000;
    n = (int'(w) + 1) * 8;
    for (int i = 0; i < 32; i++) begin
      if (i < n) begin
        r[i] = d[n - 1 - i];
      end
    end
    return r;
  endfunction : mirror

  // one byte through the selected algorithm, returns {carry, value}
  function automatic logic [32:0] step(
    input algo_e      a,
    input logic [31:0] v,
    input logic        c,
    input logic [7:0]  b,
    input logic [1:0]  k,
    input logic        nc
  );
    logic [32:0] sum;
    logic [31:0] crc;
    logic [31:0] poly;
    logic        cin;
    logic        fb;
    int          top;
    sum  = 33'h0_0000_0000;
    crc  = v;
    poly = POLY_CRC16A;
    cin  = c & ~nc;
    fb   = 1'b0;
    top  = 15;
    case (a)
      ALG_SUM8: begin
        sum = 33'(v[7:0]) + 33'(b) + 33'(cin);
        return {sum[8], 24'h00_0000, sum[7:0]};
      end
      ALG_SUM32: begin
        // carry from the last word only enters at the lowest lane
        sum = {1'b0, v} + (33'(b) << {k, 3'b000}) + 33'((k == 2'd0) & cin);
        return {((k != 2'd0) & c) | sum[32], sum[31:0]};
      end
      ALG_CRC16A, ALG_CRC16B, ALG_CRC32: begin
        if (a == ALG_CRC16B) begin
          poly = POLY_CRC16B;
        end else if (a == ALG_CRC32) begin
          poly = POLY_CRC32;
          top  = 31;
        end
        for (int i = 0; i < 8; i++) begin
          fb  = crc[top] ^ b[i];
          crc = crc << 1;
          if (fb) begin
            crc = crc ^ poly;
          end
        end
        if (a != ALG_CRC32) begin
          crc[31:16] = 16'h0000;
        end
        return {c, crc};
      end
      default: begin
        return {c, v};
      end
    endcase
  endfunction : step

  function automatic logic [31:0] default_seed(input algo_e a);
    case (a)
      ALG_CRC16A, ALG_CRC16B: default_seed = SEED_CRC16;
      ALG_CRC32:              default_seed = SEED_CRC32;
      default:                default_seed = SEED_SUM;
    endcase
  endfunction : default_seed

  // ============================================================
  // write decode
  assign is_data0   = (wr_addr == DATA0_ADDR) & wr_lane0;
  assign is_clear   = (wr_addr == CFG_ADDR) & wr_lane0 & (wr_byte[2:0] == ALG_CLEAR);
  assign needs_push = is_data0 | is_clear;
  // a full buffer holds the write response back
  assign commit     = !awready & !wready & !bvalid & (!needs_push | push_ready);
  assign push_valid = !awready & !wready & !bvalid & needs_push;

  always_comb begin
    engine_input_word = {data_hold, wr_byte} & width_mask(input_width_select);
    if (reverse_order && !seed_entry) begin
      engine_input_word = mirror(engine_input_word, input_width_select);
    end
    push_entry.nbytes = input_width_select;
    push_entry.word   = engine_input_word;
    if (is_clear) begin
      push_entry.kind = ENT_CLEAR;
    end else if (seed_entry) begin
      push_entry.kind = ENT_SEED;
    end else begin
      push_entry.kind = ENT_DATA;
    end
  end

  // ============================================================
  // axi write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      wr_addr  <= '0;
      wr_byte  <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        wr_byte  <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end
      if (commit) begin
        bvalid <= 1'b1;
        case (wr_addr)
          CFG_ADDR, DATA0_ADDR, DATA1_ADDR, DATA2_ADDR, DATA3_ADDR: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ============================================================
  // configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_width_select <= CFG_RESET[WIDTH_LSB +: 2];
      reverse_order      <= CFG_RESET[REV_BIT];
      carry_discard      <= CFG_RESET[CARRY_BIT];
      seed_entry         <= CFG_RESET[SEED_BIT];
      algorithm_select   <= algo_e'(CFG_RESET[ALG_LSB +: 3]);
    end else if (commit && wr_lane0 && wr_addr == CFG_ADDR) begin
      input_width_select <= wr_byte[WIDTH_LSB +: 2];
      reverse_order      <= wr_byte[REV_BIT];
      carry_discard      <= wr_byte[CARRY_BIT];
      seed_entry         <= wr_byte[SEED_BIT];
      if (wr_byte[ALG_LSB +: 3] != ALG_CLEAR) begin
        algorithm_select <= algo_e'(wr_byte[ALG_LSB +: 3]);
      end
    end
  end

  // ============================================================
  // upper data bytes wait here for the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_hold <= DATA_RESET[31:8];
    end else if (commit && wr_lane0) begin
      case (wr_addr)
        DATA1_ADDR: data_hold[15:8]  <= wr_byte;
        DATA2_ADDR: data_hold[23:16] <= wr_byte;
        DATA3_ADDR: data_hold[31:24] <= wr_byte;
        default:    data_hold        <= data_hold;
      endcase
    end
  end

  accel_pair_buffer #(
    .WIDTH (ENTRY_W),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_entry),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_entry)
  );

  // ============================================================
  // engine: one byte per clock, the first byte in the pop cycle
  assign pop_ready = (state == ST_IDLE);
  assign step_byte = (state == ST_IDLE) ? pop_entry.word[7:0] : cur_word[{lane, 3'b000} +: 8];
  assign step_lane = (state == ST_IDLE) ? 2'd0 : lane;
  assign step_out  = step(algorithm_select, acc, carry, step_byte, step_lane, carry_discard);
  assign busy      = pop_valid | (state == ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      acc      <= DATA_RESET;
      carry    <= 1'b0;
      cur_word <= 32'h0000_0000;
      cur_last <= 2'd0;
      lane     <= 2'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pop_valid) begin
            case (pop_entry.kind)
              ENT_CLEAR: begin
                acc   <= default_seed(algorithm_select);
                carry <= 1'b0;
              end
              ENT_SEED: begin
                acc <= pop_entry.word;
              end
              default: begin
                // an engine that is off or reserved drops the word
                if (algorithm_select inside {ALG_SUM8, ALG_SUM32, ALG_CRC16A, ALG_CRC16B, ALG_CRC32}) begin
                  acc   <= step_out[31:0];
                  carry <= step_out[32];
                  if (pop_entry.nbytes != 2'd0) begin
                    cur_word <= pop_entry.word;
                    cur_last <= pop_entry.nbytes;
                    lane     <= 2'd1;
                    state    <= ST_RUN;
                  end
                end
              end
            endcase
          end
        end
        ST_RUN: begin
          acc   <= step_out[31:0];
          carry <= step_out[32];
          lane  <= lane + 2'd1;
          if (lane == cur_last) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // axi read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= RESP_OKAY;
        case (araddr)
          CFG_ADDR: begin
            rdata <= {24'h00_0000, input_width_select, reverse_order, carry_discard,
                      seed_entry, 2'b00, busy};
          end
          DATA0_ADDR: rdata <= {24'h00_0000, acc[7:0]};
          DATA1_ADDR: rdata <= {24'h00_0000, acc[15:8]};
          DATA2_ADDR: rdata <= {24'h00_0000, acc[23:16]};
          DATA3_ADDR: rdata <= {24'h00_0000, acc[31:24]};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : checksum_crc_accelerator

`default_nettype wire

// ### dv/accel_props.sv
// concurrent checks on the register port of the accelerator
`timescale 1ns/1ps
`default_nettype none

module accel_props
  import accel_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0]        awprot,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0]        arprot,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready
);
  // ============================================================
  // addresses of the transfers under way
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic              rd_map;
  logic              wr_map;

  always_ff @(posedge aclk) begin
    if (arvalid && arready) rd_addr <= araddr;
  end
  always_ff @(posedge aclk) begin
    if (awvalid && awready) wr_addr <= awaddr;
  end
  assign rd_map = rd_addr inside {CFG_ADDR, DATA0_ADDR, DATA1_ADDR, DATA2_ADDR, DATA3_ADDR};
  assign wr_map = wr_addr inside {CFG_ADDR, DATA0_ADDR, DATA1_ADDR, DATA2_ADDR, DATA3_ADDR};

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ============================================================
  // assertions
  chk_b_stands:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  chk_r_stands:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  chk_r_latency:
    assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  chk_cfg_write_answer:
    assert property (awvalid && awready && wvalid && wready && awaddr == CFG_ADDR && wdata[2:0] != 3'h7
      |-> ##[1:2] bvalid) else $error("config write answer late");
  chk_aw_blocked:
    assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
  chk_ar_blocked:
    assert property (rvalid |-> !arready) else $error("read taken during response");
  chk_cfg_zero_bits:
    assert property (rvalid && rd_addr == CFG_ADDR |-> rdata[2:1] == 2'b00 && rresp == RESP_OKAY)
      else $error("config read bits wrong");
  chk_rd_unmapped:
    assert property (rvalid && !rd_map |-> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read answered");
  chk_wr_resp_code:
    assert property (bvalid |-> bresp == (wr_map ? RESP_OKAY : RESP_SLVERR)) else $error("write resp code wrong");
  chk_rdata_upper:
    assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("read upper bits set");
endmodule : accel_props

bind checksum_crc_accelerator accel_props u_props (
  .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);

`default_nettype wire

// ### dv/cpu_bus_model.sv
// bus master standing in for the cpu on the register port
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model
  import accel_pkg::*;
(
  input  wire logic              aclk,
  output logic      [ADDR_W-1:0] awaddr,
  output logic      [2:0]        awprot,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic      [31:0]       wdata,
  output logic      [3:0]        wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic      [ADDR_W-1:0] araddr,
  output logic      [2:0]        arprot,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  initial begin
    {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} <= '0;
    {araddr, arprot, arvalid, rready} <= '0;
  end

  // ============================================================
  // transfers; released lines show inverted values, not the old ones
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wready && !dd) begin
        dd = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~{24'h00_0000, d};
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // high bytes first, the low byte last completes the word
  task automatic wr_word(input logic [31:0] v, input int nb);
    logic [1:0] r;
    for (int k = nb - 1; k >= 0; k--) wr(DATA0_ADDR + ADDR_W'(4 * k), v[8*k +: 8], r);
  endtask : wr_word
endmodule : cpu_bus_model

`default_nettype wire

// ### dv/checksum_crc_accelerator_tb.sv
// self-checking bench for the checksum and crc accelerator
`timescale 1ns/1ps
`default_nettype none

module checksum_crc_accelerator_tb
  import accel_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_mismatch = 0;
  int comparisons = 0;
  algo_e algs [3] = '{ALG_CRC16A, ALG_CRC16B, ALG_CRC32};
  logic [31:0] polys [3] = '{POLY_CRC16A, POLY_CRC16B, POLY_CRC32};
  logic [31:0] seeds [3] = '{SEED_CRC16, SEED_CRC16, SEED_CRC32};
  logic [31:0] last;

  always #12.5 aclk = ~aclk;

  checksum_crc_accelerator dut (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  cpu_bus_model cpu (
    .aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  // ============================================================
  // compare and access tasks
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    cpu.wr(a, d, r);
    cmp("bresp", 32'(er), 32'(r));
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.rd(a, d, r);
    cmp("rdata", e, d);
    cmp("rresp", 32'(er), 32'(r));
  endtask : rd

  // polls busy first: this master is faster than the cpu it stands in for
  task automatic res(input logic [31:0] e);
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    d = 32'h1;
    for (int i = 0; i < 32 && d[0] !== 1'b0; i++) cpu.rd(CFG_ADDR, d, r);
    cmp("busy", 32'h0, 32'(d[0]));
    for (int k = 0; k < 4; k++) begin
      cpu.rd(DATA0_ADDR + ADDR_W'(4 * k), d, r);
      v[8*k +: 8] = d[7:0];
    end
    cmp("result", e, v);
  endtask : res

  // msb-fed shift register, byte bits taken from bit 0 up
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [31:0] p, input int w,
                                       input logic [7:0] b);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[w-1] ^ b[i];
      c = c << 1;
      if (fb) c = c ^ p;
    end
    return (w == 16) ? (c & 32'h0000_ffff) : c;
  endfunction : crc8

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop();
  end

  // ============================================================
  // scenarios
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CFG_ADDR, 32'h0, RESP_OKAY);
    res(DATA_RESET);
    rd(CFG_ADDR + 18'h0_0004, 32'h0, RESP_SLVERR);
    wr(CFG_ADDR + 18'h0_0004, 8'hff, RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      wr(CFG_ADDR, {3'b000, i[0], 4'h1}, RESP_OKAY);
      wr(CFG_ADDR, {3'b000, i[0], 4'h7}, RESP_OKAY);
      res(SEED_SUM);
      rd(CFG_ADDR, {24'h00_0000, 3'b000, i[0], 4'h0}, RESP_OKAY);
      wr(DATA0_ADDR, 8'hf0, RESP_OKAY);
      wr(DATA0_ADDR, 8'h20, RESP_OKAY);
      wr(DATA0_ADDR, 8'h01, RESP_OKAY);
      res(i ? 32'h11 : 32'h12);
    end
    wr(CFG_ADDR, 8'h00, RESP_OKAY);
    wr(DATA0_ADDR, 8'h33, RESP_OKAY);
    res(32'h11);
    wr(CFG_ADDR, 8'h39, RESP_OKAY);
    wr(DATA0_ADDR, 8'h81, RESP_OKAY);
    res(32'h81);
    wr(CFG_ADDR, 8'h31, RESP_OKAY);
    wr(DATA0_ADDR, 8'h01, RESP_OKAY);
    res(32'h01);
    wr(CFG_ADDR, 8'h02, RESP_OKAY);
    wr(CFG_ADDR, 8'h07, RESP_OKAY);
    wr(CFG_ADDR, 8'hc2, RESP_OKAY);
    cpu.wr_word(32'h0102_0304, 4);
    // read right behind a 32-bit word lands while the engine is still on its lanes
    rd(CFG_ADDR, 32'h0000_00c1, RESP_OKAY);
    res(32'h0102_0304);
    wr(CFG_ADDR, 8'h42, RESP_OKAY);
    wr(DATA3_ADDR, 8'h77, RESP_OKAY);
    wr(DATA1_ADDR, 8'haa, RESP_OKAY);
    wr(DATA0_ADDR, 8'h55, RESP_OKAY);
    res(32'h0102_ad59);
    wr(CFG_ADDR, 8'h82, RESP_OKAY);
    cpu.wr_word(32'h0010_0000, 3);
    res(32'h0112_ad59);
    wr(CFG_ADDR, 8'h62, RESP_OKAY);
    cpu.wr_word(32'h0000_0001, 2);
    res(32'h0113_2d59);
    for (int k = 0; k < 3; k++) begin
      wr(CFG_ADDR, {5'h00, algs[k]}, RESP_OKAY);
      wr(CFG_ADDR, 8'h07, RESP_OKAY);
      res(seeds[k]);
      wr(DATA0_ADDR, 8'h5a, RESP_OKAY);
      last = crc8(seeds[k], polys[k], (k == 2) ? 32 : 16, 8'h5a);
      res(last);
    end
    wr(CFG_ADDR, 8'h06, RESP_OKAY);
    wr(DATA0_ADDR, 8'h5a, RESP_OKAY);
    res(last);
    report_and_stop();
  end
endmodule : checksum_crc_accelerator_tb

`default_nettype wire
